// ### rtl/field_formatter.sv
// field formatter: capture scan, walk records, emit header/data/trailer
// Contract
// - keyboard mode maps each byte to keystroke
// - keyboard mode drops controls except HT LF CR ESC
// - keyboard mode drops bytes with top bit set
// - keyboard mode nul ends the string
// - serial mode passes raw bytes unchanged
// - scan continues until read or trigger release
// - send data as soon as read completes
// - new scan needs trigger release and repull
// - arrays of 64 records, four fields each
// - field bytes ascend start to start+len-1
// - length accepts zero to ten-bit maximum
// - zero length record ends interpretation
// - header of zero to four characters first
// - trailer of zero to four characters after
// - records processed in order, header data trailer
// - record starts may be in any order
// - three arrays, one per scan step
// - arrays writable, never read back
// - start beyond data: header, trailer, error
// - length past end: available bytes, trailer, error
// - captured string truncated at 1024 bytes
// assumes trigger is a raw pin; scan bytes come from the reader on clk
`timescale 1ns/1ps
module field_formatter
    import fmt_pkg::*;
#(
    parameter int unsigned FIFO_D = fmt_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // trigger pin and reader control
    input wire logic trigger_pin,
    output logic scan_active,
    // reader byte stream, last marks read complete
    input wire logic scan_valid,
    input wire fmt_pkg::scan_byte_t scan_in,
    // configuration
    input wire logic kbd_mode,
    input wire logic interp_en,
    input wire logic [fmt_pkg::ARR_IDX_W-1:0] seq_steps,
    input wire logic rec_wr_en,
    input wire fmt_pkg::rec_wr_t rec_wr,
    // host stream
    output logic host_valid,
    input wire logic host_ready,
    output logic [7:0] host_data,
    // status
    output logic field_err,
    output logic done_pulse
);
    typedef enum logic [6:0] {
        S_IDLE = 7'b0000001,
        S_SCAN = 7'b0000010,
        S_LOAD = 7'b0000100,
        S_HDR = 7'b0001000,
        S_DATA = 7'b0010000,
        S_TRL = 7'b0100000,
        S_WAIT = 7'b1000000
    } state_t;

    state_t st_q;
    logic [2:0] trig_sync_q;
    logic trig_q;
    logic [7:0] buf_mem [MAX_DATA_LEN];
    record_t rec_mem [NUM_ARRAYS*MAX_RECORDS];
    logic [ADDR_W-1:0] cap_len_q, pos_q, end_q;
    logic [REC_IDX_W-1:0] rec_q;
    logic [ARR_IDX_W-1:0] step_q;
    logic [AFFIX_CNT_W-1:0] aff_q;
    logic whole_q, nul_seen_q, err_q, done_q;
    record_t cur_q;
    logic [7:0] cand;
    logic cand_v, pass, is_nul, f_ready, stall;
    logic [ADDR_W-1:0] rd_addr;
    logic [7:0] rd_byte;
    logic [7:0] hdr_ch, trl_ch;

    // three stages; only the last two are compared
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trig_sync_q <= '0;
            trig_q <= 1'b0;
        end else begin
            trig_sync_q <= {trig_sync_q[1:0], trigger_pin};
            if (trig_sync_q[2] == trig_sync_q[1]) begin
                trig_q <= trig_sync_q[2];
            end
        end
    end

    // write only; no read port reaches the host
    always_ff @(posedge clk) begin
        if (rec_wr_en && rec_wr.arr < NUM_ARRAYS[ARR_IDX_W-1:0]) begin
            rec_mem[{rec_wr.arr, rec_wr.idx}] <= rec_wr.rec;
        end
    end

    always_ff @(posedge clk) begin
        if (st_q == S_SCAN && scan_valid && cap_len_q < ADDR_W'(MAX_DATA_LEN)) begin
            buf_mem[cap_len_q[LEN_W-1:0]] <= scan_in.data;
        end
    end

    assign rd_addr = whole_q ? pos_q : pos_q;
    assign rd_byte = buf_mem[rd_addr[LEN_W-1:0]];
    assign hdr_ch = cur_q.hdr[(AFFIX_CHARS-1-32'(aff_q))*DATA_W +: DATA_W];
    assign trl_ch = cur_q.trl[(AFFIX_CHARS-1-32'(aff_q))*DATA_W +: DATA_W];
    assign scan_active = (st_q == S_SCAN);

    always_comb begin
        cand = 8'h00;
        cand_v = 1'b0;
        unique case (st_q)
            S_HDR: begin
                cand = hdr_ch;
                cand_v = (aff_q < cur_q.hdr_cnt) && (aff_q < AFFIX_CNT_W'(AFFIX_CHARS));
            end
            S_DATA: begin
                cand = rd_byte;
                cand_v = (pos_q < end_q);
            end
            S_TRL: begin
                cand = trl_ch;
                cand_v = (aff_q < cur_q.trl_cnt) && (aff_q < AFFIX_CNT_W'(AFFIX_CHARS));
            end
            default: begin
                cand = 8'h00;
                cand_v = 1'b0;
            end
        endcase
    end

    kbd_filter u_filt (
        .byte_in(cand),
        .kbd_mode(kbd_mode),
        .pass(pass),
        .is_nul(is_nul)
    );

    // fifo back-pressure stalls the walk
    assign stall = cand_v && !nul_seen_q && pass && !is_nul && !f_ready;

    out_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_D)
    ) u_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .in_valid(cand_v && !nul_seen_q && pass && !is_nul),
        .in_ready(f_ready),
        .in_data(cand),
        .out_valid(host_valid),
        .out_ready(host_ready),
        .out_data(host_data)
    );

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= S_IDLE;
            cap_len_q <= '0;
            pos_q <= '0;
            end_q <= '0;
            rec_q <= '0;
            step_q <= '0;
            aff_q <= '0;
            whole_q <= 1'b0;
            nul_seen_q <= 1'b0;
            err_q <= 1'b0;
            done_q <= 1'b0;
            cur_q <= '0;
        end else begin
            done_q <= 1'b0;
            if (!stall && cand_v && is_nul) begin
                nul_seen_q <= 1'b1;
            end
            unique case (st_q)
                S_IDLE: begin
                    if (trig_q) begin
                        st_q <= S_SCAN;
                        cap_len_q <= '0;
                        err_q <= 1'b0;
                        nul_seen_q <= 1'b0;
                    end
                end
                S_SCAN: begin
                    if (!trig_q) begin
                        st_q <= S_IDLE;
                    end else if (scan_valid) begin
                        if (cap_len_q < ADDR_W'(MAX_DATA_LEN)) begin
                            cap_len_q <= cap_len_q + 1'b1;
                        end
                        if (scan_in.last) begin
                            st_q <= S_LOAD;
                            rec_q <= '0;
                            whole_q <= !interp_en;
                        end
                    end
                end
                S_LOAD: begin
                    aff_q <= '0;
                    if (whole_q) begin
                        cur_q <= '0;
                        pos_q <= '0;
                        end_q <= cap_len_q;
                        st_q <= S_DATA;
                    end else if (rec_mem[{step_q, rec_q}].len == LEN_END) begin
                        st_q <= S_WAIT;
                        done_q <= 1'b1;
                    end else begin
                        cur_q <= rec_mem[{step_q, rec_q}];
                        st_q <= S_HDR;
                    end
                end
                S_HDR: begin
                    if (!stall) begin
                        if (cand_v) begin
                            aff_q <= aff_q + 1'b1;
                        end else begin
                            aff_q <= '0;
                            pos_q <= cur_q.start;
                            if (cur_q.start >= cap_len_q) begin
                                end_q <= cur_q.start;
                                err_q <= 1'b1;
                                st_q <= S_TRL;
                            end else begin
                                if ({1'b0, cur_q.start} + {2'b00, cur_q.len} > {1'b0, cap_len_q}) begin
                                    end_q <= cap_len_q;
                                    err_q <= 1'b1;
                                end else begin
                                    end_q <= cur_q.start + ADDR_W'(cur_q.len);
                                end
                                st_q <= S_DATA;
                            end
                        end
                    end
                end
                S_DATA: begin
                    if (!stall) begin
                        if (cand_v) begin
                            pos_q <= pos_q + 1'b1;
                        end else if (whole_q) begin
                            st_q <= S_WAIT;
                            done_q <= 1'b1;
                        end else begin
                            st_q <= S_TRL;
                        end
                    end
                end
                S_TRL: begin
                    if (!stall) begin
                        if (cand_v) begin
                            aff_q <= aff_q + 1'b1;
                        end else if (rec_q == REC_IDX_W'(MAX_RECORDS-1)) begin
                            st_q <= S_WAIT;
                            done_q <= 1'b1;
                        end else begin
                            rec_q <= rec_q + 1'b1;
                            st_q <= S_LOAD;
                        end
                    end
                end
                S_WAIT: begin
                    if (!trig_q) begin
                        st_q <= S_IDLE;
                        step_q <= (step_q >= seq_steps || step_q == ARR_IDX_W'(NUM_ARRAYS-1))
                            ? '0 : step_q + 1'b1;
                    end
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end

    assign field_err = err_q;
    assign done_pulse = done_q;

    property p_rearm;
        @(posedge clk) disable iff (!arst_n)
        (st_q == S_WAIT) && trig_q |=> (st_q == S_WAIT);
    endproperty
    a_rearm: assert property (p_rearm) else $error("scan restarted without release");

    property p_abort;
        @(posedge clk) disable iff (!arst_n)
        (st_q == S_SCAN) && !trig_q |=> (st_q == S_IDLE);
    endproperty
    a_abort: assert property (p_abort) else $error("scan kept after release");

    property p_drop_high;
        @(posedge clk) disable iff (!arst_n)
        kbd_mode && cand_v && cand[7] |-> !u_fifo.push;
    endproperty
    a_drop_high: assert property (p_drop_high) else $error("high byte sent in keyboard mode");

    property p_drop_del;
        @(posedge clk) disable iff (!arst_n)
        kbd_mode && cand == CH_DEL |-> !u_fifo.push;
    endproperty
    a_drop_del: assert property (p_drop_del) else $error("delete sent in keyboard mode");

    property p_raw;
        @(posedge clk) disable iff (!arst_n)
        !kbd_mode && cand_v && f_ready && !nul_seen_q |-> u_fifo.push;
    endproperty
    a_raw: assert property (p_raw) else $error("serial byte dropped");

    property p_nul;
        @(posedge clk) disable iff (!arst_n)
        nul_seen_q && st_q != S_IDLE |-> !u_fifo.push;
    endproperty
    a_nul: assert property (p_nul) else $error("byte sent after nul");

    property p_cap;
        @(posedge clk) disable iff (!arst_n)
        cap_len_q <= ADDR_W'(MAX_DATA_LEN);
    endproperty
    a_cap: assert property (p_cap) else $error("capture over limit");

    sequence s_bad_start;
        (st_q == S_HDR) && !cand_v && !stall && (cur_q.start >= cap_len_q);
    endsequence
    property p_bad_start;
        @(posedge clk) disable iff (!arst_n)
        s_bad_start |=> (st_q == S_TRL) && field_err;
    endproperty
    a_bad_start: assert property (p_bad_start) else $error("bad start not flagged");

    property p_overrun;
        @(posedge clk) disable iff (!arst_n)
        (st_q == S_HDR) && !cand_v && !stall && (cur_q.start < cap_len_q)
            && ({1'b0, cur_q.start} + {2'b00, cur_q.len} > {1'b0, cap_len_q}) |=> field_err && (end_q == cap_len_q);
    endproperty
    a_overrun: assert property (p_overrun) else $error("field overrun not flagged");

    property p_ascend;
        @(posedge clk) disable iff (!arst_n)
        (st_q == S_DATA) && cand_v && !stall |=> pos_q == $past(pos_q) + 1'b1;
    endproperty
    a_ascend: assert property (p_ascend) else $error("field bytes out of order");

    property p_end;
        @(posedge clk) disable iff (!arst_n)
        (st_q == S_LOAD) && !whole_q && rec_mem[{step_q, rec_q}].len == LEN_END |=> (st_q == S_WAIT);
    endproperty
    a_end: assert property (p_end) else $error("zero length did not end");
endmodule

// ### common/fmt_pkg.sv
// types and constants for the scan data field formatter
// assumes one 25 MHz clock domain
package fmt_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned MAX_DATA_LEN = 1024;
    localparam int unsigned LEN_W = 10;
    localparam int unsigned ADDR_W = 11;
    localparam int unsigned MAX_RECORDS = 64;
    localparam int unsigned REC_IDX_W = 6;
    localparam int unsigned NUM_ARRAYS = 3;
    localparam int unsigned ARR_IDX_W = 2;
    localparam int unsigned AFFIX_CHARS = 4;
    localparam int unsigned AFFIX_CNT_W = 3;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam logic [7:0] CH_NUL = 8'h00;
    localparam logic [7:0] CH_HT = 8'h09;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_ESC = 8'h1B;
    localparam logic [7:0] CH_SP = 8'h20;
    localparam logic [7:0] CH_DEL = 8'h7F;
    localparam logic [9:0] LEN_END = 10'h000;

    typedef struct packed {
        logic [ADDR_W-1:0] start;
        logic [LEN_W-1:0] len;
        logic [AFFIX_CNT_W-1:0] hdr_cnt;
        logic [AFFIX_CHARS*DATA_W-1:0] hdr;
        logic [AFFIX_CNT_W-1:0] trl_cnt;
        logic [AFFIX_CHARS*DATA_W-1:0] trl;
    } record_t;

    typedef struct packed {
        logic [ARR_IDX_W-1:0] arr;
        logic [REC_IDX_W-1:0] idx;
        record_t rec;
    } rec_wr_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic last;
    } scan_byte_t;
endpackage

// ### rtl/out_fifo.sv
// small valid/ready fifo for the outgoing byte stream
// assumes a single clock; width and depth are parameters
`timescale 1ns/1ps
module out_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wp_q, rp_q;
    logic [PW:0] cnt_q;
    logic push, pop;

    assign in_ready = (cnt_q != DEPTH[PW:0]);
    assign out_valid = (cnt_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rp_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == PW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == PW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

// ### rtl/kbd_filter.sv
// keystroke filter: decides whether one byte may go out
// combinational; the caller keeps the nul-seen state
`timescale 1ns/1ps
module kbd_filter (
    // byte under test
    input wire logic [7:0] byte_in,
    input wire logic kbd_mode,
    // verdict
    output logic pass,
    output logic is_nul
);
    import fmt_pkg::*;
    logic ctrl_ok;

    assign is_nul = kbd_mode && (byte_in == CH_NUL);
    assign ctrl_ok = (byte_in == CH_HT) || (byte_in == CH_LF) || (byte_in == CH_CR) || (byte_in == CH_ESC);

    always_comb begin
        if (!kbd_mode) begin
            pass = 1'b1;
        end else if (byte_in[7]) begin
            pass = 1'b0;
        end else if (byte_in == CH_DEL) begin
            pass = 1'b0;
        end else if (byte_in < CH_SP) begin
            pass = ctrl_ok;
        end else begin
            pass = 1'b1;
        end
    end
endmodule

// ### sim/host_model.sv
// host side of the formatter: drains the output stream, logs every byte taken
// assumes the testbench clears and reads the log between reads
`timescale 1ns/1ps
module host_model (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // stall request from the testbench
    input wire logic hold,
    // output stream of the formatter
    input wire logic host_valid,
    output logic host_ready,
    input wire logic [7:0] host_data
);
    logic [7:0] got[$];

    initial host_ready = 1'b0;

    // random stalls plus a forced hold so the fifo fills and refuses
    always @(negedge clk) begin
        host_ready <= !hold && (($urandom % 3) != 0);
    end

    always @(posedge clk) begin
        if (arst_n && host_valid === 1'b1 && host_ready) begin
            got.push_back(host_data);
        end
    end
endmodule

// ### sim/testbench.sv
// self-checking bench for the field formatter with a stalling host model
// assumes one 25 MHz clock; expectations come from the bench's own record copy
`timescale 1ns/1ps
module testbench;
    import fmt_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic trigger_pin = 1'b0;
    logic scan_valid = 1'b0;
    logic kbd_mode = 1'b0;
    logic interp_en = 1'b0;
    logic rec_wr_en = 1'b0;
    logic hold = 1'b0;
    logic [ARR_IDX_W-1:0] seq_steps = 2'h2;
    scan_byte_t scan_in = '0;
    rec_wr_t rec_wr = '0;
    logic scan_active, host_valid, host_ready, field_err, done_pulse;
    logic [7:0] host_data;
    int n_fail = 0;
    int n_compared = 0;
    int cycles = 0;
    int arr_ptr = 0;
    record_t recs[3][64];
    logic [7:0] dat[$];
    logic [7:0] exp[$];
    logic exp_err, stop;

    field_formatter #(.FIFO_D(8)) field_formatter_i (.clk(clk), .arst_n(arst_n), .trigger_pin(trigger_pin),
        .scan_active(scan_active), .scan_valid(scan_valid), .scan_in(scan_in), .kbd_mode(kbd_mode),
        .interp_en(interp_en), .seq_steps(seq_steps), .rec_wr_en(rec_wr_en), .rec_wr(rec_wr),
        .host_valid(host_valid), .host_ready(host_ready), .host_data(host_data), .field_err(field_err),
        .done_pulse(done_pulse));
    host_model host_model_i (.clk(clk), .arst_n(arst_n), .hold(hold), .host_valid(host_valid),
        .host_ready(host_ready), .host_data(host_data));

    always #20 clk = ~clk;

    task results;
        if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // the whole run needs well under this many cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            results();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
        n_compared++;
        if (seen !== expv) begin
            n_fail++;
            $display("unexpected %s expected %0h seen %0h", name, expv, seen);
        end
    endtask

    task automatic put(input int i, input int st, input int ln, input int hc, input int tc);
        record_t r;
        r.start = ADDR_W'(st);
        r.len = LEN_W'(ln);
        r.hdr_cnt = AFFIX_CNT_W'(hc);
        r.trl_cnt = AFFIX_CNT_W'(tc);
        for (int k = 0; k < 4; k++) begin
            r.hdr[8*k +: 8] = 8'h21 + 8'($urandom % 94);
            r.trl[8*k +: 8] = 8'h21 + 8'($urandom % 94);
        end
        recs[arr_ptr][i] = r;
        @(negedge clk);
        rec_wr_en = 1'b1;
        rec_wr = '{arr: ARR_IDX_W'(arr_ptr), idx: REC_IDX_W'(i), rec: r};
        @(negedge clk);
        rec_wr_en = 1'b0;
    endtask

    function automatic logic kbd_ok(input logic [7:0] b);
        return !b[7] && ((b >= CH_SP && b != CH_DEL) || b == CH_HT || b == CH_LF || b == CH_CR || b == CH_ESC);
    endfunction

    // a nul in keyboard mode silences the rest of the read, trailers too
    task automatic emit(input logic [7:0] b);
        if (kbd_mode && b == CH_NUL) stop = 1'b1;
        else if (!stop && (!kbd_mode || kbd_ok(b))) exp.push_back(b);
    endtask

    task automatic build;
        record_t r;
        int n;
        n = (dat.size() > int'(MAX_DATA_LEN)) ? int'(MAX_DATA_LEN) : dat.size();
        exp = {};
        exp_err = 1'b0;
        stop = 1'b0;
        if (!interp_en) begin
            for (int i = 0; i < n; i++) emit(dat[i]);
            return;
        end
        for (int j = 0; j < int'(MAX_RECORDS); j++) begin
            r = recs[arr_ptr][j];
            if (r.len == LEN_END) break;
            for (int k = 0; k < r.hdr_cnt; k++) emit(r.hdr[31-8*k -: 8]);
            for (int i = r.start; i < r.start + r.len && i < n; i++) emit(dat[i]);
            for (int k = 0; k < r.trl_cnt; k++) emit(r.trl[31-8*k -: 8]);
            if (r.start + r.len > n) exp_err = 1'b1;
        end
    endtask

    task automatic rnd(input int n, input logic any);
        dat = {};
        for (int i = 0; i < n; i++) dat.push_back(any ? 8'($urandom) : 8'h21 + 8'($urandom % 94));
    endtask

    task automatic pull;
        int w;
        @(negedge clk);
        trigger_pin = 1'b1;
        w = 0;
        while (scan_active !== 1'b1 && w < 20) begin
            @(negedge clk);
            w++;
        end
        check("scan_active", scan_active, 1);
    endtask

    task automatic scan;
        int w;
        build();
        host_model_i.got = {};
        pull();
        hold = 1'b1;
        foreach (dat[i]) begin
            scan_valid = 1'b1;
            scan_in = '{data: dat[i], last: i == dat.size() - 1};
            @(negedge clk);
        end
        scan_valid = 1'b0;
        w = 0;
        while (w < 20000) begin
            @(posedge clk);
            #1;
            if (done_pulse === 1'b1) break;
            w++;
            if (w == 20) hold = 1'b0;
        end
        hold = 1'b0;
        check("done_pulse", done_pulse, 1);
        check("field_err", field_err, exp_err);
        // trigger still held: strobes must not start a new capture
        for (int k = 0; k < 6; k++) begin
            @(negedge clk);
            scan_valid = 1'b1;
            scan_in = '{data: 8'h55, last: 1'b0};
            check("scan_active_held", scan_active, 0);
        end
        @(negedge clk);
        scan_valid = 1'b0;
        trigger_pin = 1'b0;
        w = 0;
        while (host_model_i.got.size() < exp.size() && w < 5000) begin
            @(negedge clk);
            w++;
        end
        repeat (10) @(negedge clk);
        check("out_count", host_model_i.got.size(), exp.size());
        foreach (exp[i]) if (i < host_model_i.got.size()) check("out_byte", host_model_i.got[i], exp[i]);
        arr_ptr = (arr_ptr == 2) ? 0 : arr_ptr + 1;
    endtask

    initial begin
        void'($urandom(64802));
        repeat (4) @(posedge clk);
        check("host_valid_rst", host_valid, 0);
        @(negedge clk);
        arst_n = 1'b1;
        for (int a = 0; a < 3; a++) begin
            arr_ptr = a;
            put(0, 0, 0, 0, 0);
        end
        arr_ptr = 0;
        // serial, whole string: every byte value passes raw
        dat = {};
        for (int i = 0; i < 256; i++) dat.push_back(8'(i));
        scan();
        // keyboard, whole string: every value, then nul, then a tail to suppress
        kbd_mode = 1'b1;
        rnd(20, 1'b0);
        dat.push_front(CH_NUL);
        for (int i = 255; i > 0; i--) dat.push_front(8'(i));
        scan();
        // 64 records, descending starts, affix counts 0..4
        kbd_mode = 1'b0;
        interp_en = 1'b1;
        rnd(64, 1'b1);
        for (int i = 0; i < 64; i++) put(i, 63 - i, 1, i % 5, (i + 2) % 5);
        scan();
        // start beyond data, then a field running past the end
        rnd(50, 1'b1);
        put(0, 60, 3, 1, 1);
        put(1, 49, 15, 2, 0);
        put(2, 0, 0, 0, 0);
        scan();
        // maximum length over an over-long capture
        rnd(1030, 1'b1);
        put(0, 2, 'h3FF, 4, 4);
        put(1, 0, 0, 0, 0);
        scan();
        // keyboard with records: nul inside a field ends the read
        kbd_mode = 1'b1;
        rnd(20, 1'b0);
        dat[5] = 8'h00;
        put(0, 0, 4, 1, 1);
        put(1, 3, 6, 1, 2);
        put(2, 0, 0, 0, 0);
        scan();
        // trigger released before the read completes
        host_model_i.got = {};
        pull();
        scan_valid = 1'b1;
        scan_in = '{data: 8'h41, last: 1'b0};
        @(negedge clk);
        scan_valid = 1'b0;
        trigger_pin = 1'b0;
        repeat (20) @(negedge clk);
        check("scan_active_abort", scan_active, 0);
        check("abort_count", host_model_i.got.size(), 0);
        results();
    end
endmodule
